// File: rtl/eft_defs.vh
// Purpose: shared constants of the exposure and frame timing controller
// Assumes: 50 MHz system clock, 32-bit register port
// Notes  : included by bare name; definitions only
`ifndef EFT_DEFS_VH
`define EFT_DEFS_VH

// clock and line step timing
`define EFT_CLK_MHZ        50
`define EFT_LINE_STEP_NS   4560
`define EFT_LINE_STEP_CYC  ((`EFT_LINE_STEP_NS * `EFT_CLK_MHZ) / 1000)
// absolute fields are in units of 10 ns; one line step is 456 units
`define EFT_ABS_PER_STEP   10'h1C8

// register offsets (byte addresses)
`define EFT_REG_OUT_MODE   8'h00
`define EFT_REG_EXP_MODE   8'h04
`define EFT_REG_EXP_RAW    8'h08
`define EFT_REG_EXP_ABS    8'h0C
`define EFT_REG_FRM_RAW    8'h10
`define EFT_REG_FRM_ABS    8'h14
`define EFT_REG_STATUS     8'h18
`define EFT_REG_FRM_COUNT  8'h1C

// mode fields sit in bits 2:0
`define EFT_MODE_LSB       0
`define EFT_MODE_MSB       2

// output mode codes
`define EFT_OM_2T10        3'h0
`define EFT_OM_2T8         3'h1
`define EFT_OM_4T10        3'h2
`define EFT_OM_4T8         3'h3
`define EFT_OM_8T8         3'h4

// exposure control mode codes
`define EFT_XM_TRIG_EDGE   3'h0
`define EFT_XM_TRIG_LEVEL  3'h1
`define EFT_XM_TRIG_PROG   3'h2
`define EFT_XM_FREE_EDGE   3'h3
`define EFT_XM_FREE_PROG   3'h4

// status bit positions
`define EFT_ST_EXPOSING    0
`define EFT_ST_CTL_SIG     1
`define EFT_ST_TRIG_LVL    2
`define EFT_ST_CONV_BUSY   3

// reset values
`define EFT_OUT_MODE_RST   3'h0
`define EFT_EXP_MODE_RST   3'h0
`define EFT_EXP_RAW_RST    22'h000001
`define EFT_FRM_RAW_RST    22'h000100

`endif

// File: rtl/eft_abs_quant.v
// Purpose: converts an absolute time (10 ns units) to whole line steps
// Assumes: start is a one-cycle pulse; 32 cycles per conversion
// Notes  : result rounds down and is clamped to at least one step
`include "eft_defs.vh"

module eft_abs_quant #(
   parameter QW = 22
) (
   input  wire          sys_clk_in,
   input  wire          rst_n_in,
   input  wire          start_in,
   input  wire [31:0]   dividend_in,
   output reg           busy_out,
   output reg           done_out,
   output reg  [QW-1:0] quot_out
);
   reg  [8:0]  rem;
   reg  [31:0] q;
   reg  [5:0]  cnt;
   wire [9:0]  trial = {rem, q[31]};
   wire        ge    = (trial >= `EFT_ABS_PER_STEP);
   wire [9:0]  diff  = trial - `EFT_ABS_PER_STEP;
   wire [31:0] q_nxt = {q[30:0], ge};
   wire        ovf   = |q_nxt[31:QW];

   // restoring divider, one quotient bit per cycle
   always @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rem      <= 9'h000;
         q        <= 32'h00000000;
         cnt      <= 6'h00;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         quot_out <= {QW{1'b0}};
      end else begin
         done_out <= 1'b0;
         if (start_in) begin
            rem      <= 9'h000;
            q        <= dividend_in;
            cnt      <= 6'h00;
            busy_out <= 1'b1;
         end else if (busy_out) begin
            rem <= ge ? diff[8:0] : trial[8:0];
            q   <= q_nxt;
            cnt <= cnt + 6'h01;
            if (cnt == 6'h1F) begin
               busy_out <= 1'b0;
               done_out <= 1'b1;
               // quantise: whole steps only, never below one
               if (ovf)
                  quot_out <= {QW{1'b1}};
               else if (q_nxt[QW-1:0] == {QW{1'b0}})
                  quot_out <= {{(QW-1){1'b0}}, 1'b1};
               else
                  quot_out <= q_nxt[QW-1:0];
            end
         end
      end
   end
endmodule // eft_abs_quant

// File: rtl/eft_top.v
// Purpose: exposure and frame timing control with tap output formatting
// Assumes: 50 MHz sys clock; trigger and pixel clock are asynchronous pins
// Notes  : exposure and frame period are counted in 4.56 us line steps
`include "eft_defs.vh"

module eft_top #(
   parameter RAW_W = 22,
   parameter NTAP  = 8,
   parameter PIX_W = 10
) (
   input  wire                  sys_clk_in,
   input  wire                  rst_b_in,
   input  wire [7:0]            reg_addr_in,
   input  wire [31:0]           reg_wdata_in,
   input  wire                  reg_wr_in,
   input  wire                  reg_rd_in,
   output reg  [31:0]           reg_rdata_out,
   input  wire                  external_frame_trigger_in,
   input  wire                  pix_clk_in,
   input  wire [NTAP*PIX_W-1:0] src_data_in,
   input  wire                  src_valid_in,
   output wire                  src_ready_out,
   output reg  [NTAP*PIX_W-1:0] tap_data_out,
   output reg                   tap_valid_out,
   output wire [3:0]            tap_count_out,
   output wire                  pix_depth10_out,
   output reg                   exposing_out,
   output reg                   ctl_sig_out,
   output reg                   readout_start_out
);
   // the line step count fits eight bits at the clock rate in use
   localparam integer STEP_CYC_I = `EFT_LINE_STEP_CYC;
   localparam [7:0]   STEP_CYC   = STEP_CYC_I[7:0];

   // reset release synchroniser
   reg rst_meta;
   reg rst_n;
   always @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // pin synchronisers and edge detection
   reg trig_meta, trig_s, trig_d;
   reg pclk_meta, pclk_s, pclk_d;
   always @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         trig_meta <= 1'b0;
         trig_s    <= 1'b0;
         trig_d    <= 1'b0;
         pclk_meta <= 1'b0;
         pclk_s    <= 1'b0;
         pclk_d    <= 1'b0;
      end else begin
         trig_meta <= external_frame_trigger_in;
         trig_s    <= trig_meta;
         trig_d    <= trig_s;
         pclk_meta <= pix_clk_in;
         pclk_s    <= pclk_meta;
         pclk_d    <= pclk_s;
      end
   end
   wire trig_rise = trig_s & ~trig_d;
   wire pclk_rise = pclk_s & ~pclk_d;

   // configuration registers
   reg [2:0]       out_mode;
   reg [2:0]       exp_mode;
   reg [RAW_W-1:0] exp_raw;
   reg [RAW_W-1:0] frm_raw;
   reg [31:0]      frm_count;
   reg             restart;

   wire             wr_om   = reg_wr_in & (reg_addr_in == `EFT_REG_OUT_MODE);
   wire             wr_xm   = reg_wr_in & (reg_addr_in == `EFT_REG_EXP_MODE);
   wire             wr_xraw = reg_wr_in & (reg_addr_in == `EFT_REG_EXP_RAW);
   wire             wr_xabs = reg_wr_in & (reg_addr_in == `EFT_REG_EXP_ABS);
   wire             wr_fraw = reg_wr_in & (reg_addr_in == `EFT_REG_FRM_RAW);
   wire             wr_fabs = reg_wr_in & (reg_addr_in == `EFT_REG_FRM_ABS);
   wire [2:0]       wmode   = reg_wdata_in[`EFT_MODE_MSB:`EFT_MODE_LSB];
   wire [RAW_W-1:0] wraw    = reg_wdata_in[RAW_W-1:0];
   wire [RAW_W-1:0] one_raw = {{(RAW_W-1){1'b0}}, 1'b1};
   wire             om_ok   = (wmode <= `EFT_OM_8T8);
   wire             xm_ok   = (wmode <= `EFT_XM_FREE_PROG);

   // absolute-time converters: index 0 exposure, index 1 frame period
   wire [1:0]       cv_start = {wr_fabs, wr_xabs};
   wire [1:0]       cv_busy;
   wire [1:0]       cv_done;
   wire [RAW_W-1:0] cv_quot [0:1];
   genvar c;
   generate
      for (c = 0; c < 2; c = c + 1) begin : g_conv
         eft_abs_quant #(.QW(RAW_W)) u_quant (
            .sys_clk_in  (sys_clk_in),
            .rst_n_in    (rst_n),
            .start_in    (cv_start[c]),
            .dividend_in (reg_wdata_in),
            .busy_out    (cv_busy[c]),
            .done_out    (cv_done[c]),
            .quot_out    (cv_quot[c])
         );
      end
   endgenerate

   // register writes; unsupported mode codes leave the field unchanged
   always @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         out_mode <= `EFT_OUT_MODE_RST;
         exp_mode <= `EFT_EXP_MODE_RST;
         exp_raw  <= `EFT_EXP_RAW_RST;
         frm_raw  <= `EFT_FRM_RAW_RST;
         restart  <= 1'b1;
      end else begin
         restart <= 1'b0;
         if (wr_om && om_ok)
            out_mode <= wmode;
         if (wr_xm && xm_ok) begin
            exp_mode <= wmode;
            restart  <= 1'b1;
         end
         // raw or absolute exposure, whole steps of at least one
         if (wr_xraw)
            exp_raw <= (wraw == {RAW_W{1'b0}}) ? one_raw : wraw;
         else if (cv_done[0])
            exp_raw <= cv_quot[0];
         if (wr_fraw)
            frm_raw <= (wraw == {RAW_W{1'b0}}) ? one_raw : wraw;
         else if (cv_done[1])
            frm_raw <= cv_quot[1];
      end
   end

   // read data, valid in the cycle after the read strobe only
   wire [31:0] exp_abs = {{(32-RAW_W){1'b0}}, exp_raw} *
                         {22'h000000, `EFT_ABS_PER_STEP};
   wire [31:0] frm_abs = {{(32-RAW_W){1'b0}}, frm_raw} *
                         {22'h000000, `EFT_ABS_PER_STEP};
   reg  [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      case (reg_addr_in)
         `EFT_REG_OUT_MODE:  rd_mux = {29'h00000000, out_mode};
         `EFT_REG_EXP_MODE:  rd_mux = {29'h00000000, exp_mode};
         `EFT_REG_EXP_RAW:   rd_mux = {{(32-RAW_W){1'b0}}, exp_raw};
         `EFT_REG_EXP_ABS:   rd_mux = exp_abs;
         `EFT_REG_FRM_RAW:   rd_mux = {{(32-RAW_W){1'b0}}, frm_raw};
         `EFT_REG_FRM_ABS:   rd_mux = frm_abs;
         `EFT_REG_STATUS: begin
            rd_mux[`EFT_ST_EXPOSING]  = exposing_out;
            rd_mux[`EFT_ST_CTL_SIG]   = ctl_sig_out;
            rd_mux[`EFT_ST_TRIG_LVL]  = trig_s;
            rd_mux[`EFT_ST_CONV_BUSY] = |cv_busy;
         end
         `EFT_REG_FRM_COUNT: rd_mux = frm_count;
         default:            rd_mux = 32'h00000000;
      endcase
   end
   always @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n)
         reg_rdata_out <= 32'h00000000;
      else if (reg_rd_in)
         reg_rdata_out <= rd_mux;
      else
         reg_rdata_out <= 32'h00000000;
   end

   // exposure sequencer, paced by the line step
   reg  [7:0]       step_cnt;
   reg  [RAW_W-1:0] exp_left;
   reg  [RAW_W-1:0] per_left;
   reg              fr_first;
   wire             step_tick = (step_cnt == STEP_CYC - 8'h01);
   wire             per_start = fr_first | (step_tick & (per_left == one_raw));

   always @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         step_cnt          <= 8'h00;
         exp_left          <= {RAW_W{1'b0}};
         per_left          <= {RAW_W{1'b0}};
         fr_first          <= 1'b0;
         exposing_out      <= 1'b0;
         ctl_sig_out       <= 1'b0;
         readout_start_out <= 1'b0;
      end else begin
         readout_start_out <= 1'b0;
         step_cnt <= step_tick ? 8'h00 : step_cnt + 8'h01;
         if (restart) begin
            step_cnt     <= 8'h00;
            exp_left     <= {RAW_W{1'b0}};
            per_left     <= {RAW_W{1'b0}};
            fr_first     <= 1'b1;
            exposing_out <= 1'b0;
            ctl_sig_out  <= 1'b0;
         end else begin
            case (exp_mode)
               `EFT_XM_TRIG_EDGE: begin
                  ctl_sig_out <= trig_s;
                  if (trig_rise) begin
                     readout_start_out <= 1'b1;
                     exposing_out      <= 1'b1;
                  end
               end
               `EFT_XM_TRIG_LEVEL: begin
                  ctl_sig_out  <= trig_s;
                  exposing_out <= ~trig_s;
                  if (trig_rise)
                     readout_start_out <= 1'b1;
               end
               `EFT_XM_TRIG_PROG: begin
                  ctl_sig_out <= trig_s;
                  // a rise during a running exposure is ignored
                  if (trig_rise && exp_left == {RAW_W{1'b0}}) begin
                     step_cnt     <= 8'h00;
                     exp_left     <= exp_raw;
                     exposing_out <= 1'b1;
                  end else if (step_tick && exp_left != {RAW_W{1'b0}}) begin
                     exp_left <= exp_left - one_raw;
                     if (exp_left == one_raw) begin
                        exposing_out      <= 1'b0;
                        readout_start_out <= 1'b1;
                     end
                  end
               end
               `EFT_XM_FREE_EDGE, `EFT_XM_FREE_PROG: begin
                  if (per_start) begin
                     if (fr_first)
                        step_cnt <= 8'h00;
                     fr_first     <= 1'b0;
                     per_left     <= frm_raw;
                     exposing_out <= 1'b1;
                     if (exp_mode == `EFT_XM_FREE_EDGE) begin
                        ctl_sig_out       <= 1'b1;
                        readout_start_out <= 1'b1;
                     end else begin
                        ctl_sig_out <= 1'b0;
                        exp_left    <= exp_raw;
                     end
                  end else if (step_tick) begin
                     per_left <= per_left - one_raw;
                     if (exp_mode == `EFT_XM_FREE_EDGE)
                        ctl_sig_out <= 1'b0;
                     else if (exp_left != {RAW_W{1'b0}}) begin
                        exp_left <= exp_left - one_raw;
                        if (exp_left == one_raw) begin
                           ctl_sig_out       <= 1'b1;
                           exposing_out      <= 1'b0;
                           readout_start_out <= 1'b1;
                        end
                     end
                  end
               end
               default: begin
                  exposing_out <= 1'b0;
                  ctl_sig_out  <= 1'b0;
               end
            endcase
         end
      end
   end

   // frame counter, one per readout start
   always @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n)
         frm_count <= 32'h00000000;
      else if (readout_start_out)
         frm_count <= frm_count + 32'h00000001;
   end

   // tap count and depth decoded from the output mode
   reg [3:0] ntap;
   reg       depth10;
   always @* begin
      ntap    = 4'h2;
      depth10 = 1'b1;
      case (out_mode)
         `EFT_OM_2T10: begin ntap = 4'h2; depth10 = 1'b1; end
         `EFT_OM_2T8:  begin ntap = 4'h2; depth10 = 1'b0; end
         `EFT_OM_4T10: begin ntap = 4'h4; depth10 = 1'b1; end
         `EFT_OM_4T8:  begin ntap = 4'h4; depth10 = 1'b0; end
         `EFT_OM_8T8:  begin ntap = 4'h8; depth10 = 1'b0; end
         default:      begin ntap = 4'h2; depth10 = 1'b1; end
      endcase
   end
   assign tap_count_out   = ntap;
   assign pix_depth10_out = depth10;
   assign src_ready_out   = pclk_rise;

   // one pixel word per pixel clock rise
   always @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n)
         tap_valid_out <= 1'b0;
      else if (pclk_rise)
         tap_valid_out <= src_valid_in;
   end

   // per-tap formatting: unused taps zero, 8-bit keeps the upper bits
   genvar t;
   generate
      for (t = 0; t < NTAP; t = t + 1) begin : g_tap
         wire [PIX_W-1:0] pin = src_data_in[t*PIX_W +: PIX_W];
         always @(posedge sys_clk_in or negedge rst_n) begin
            if (!rst_n)
               tap_data_out[t*PIX_W +: PIX_W] <= {PIX_W{1'b0}};
            else if (pclk_rise) begin
               if (t >= ntap || !src_valid_in)
                  tap_data_out[t*PIX_W +: PIX_W] <= {PIX_W{1'b0}};
               else if (depth10)
                  tap_data_out[t*PIX_W +: PIX_W] <= pin;
               else
                  tap_data_out[t*PIX_W +: PIX_W] <=
                     {{(PIX_W-8){1'b0}}, pin[PIX_W-1:PIX_W-8]};
            end
         end
      end
   endgenerate
endmodule // eft_top

// File: dv/eft_top_props.sv
// Purpose: port-level checks of the exposure and frame timing controller
// Assumes: bound to eft_top; shadows snoop the register write port
// Notes  : shadows update on the write edge; absolute-time writes reach the registers only when the conversion is done
`include "eft_defs.vh"

module eft_top_props (
   input wire logic        sys_clk_in,
   input wire logic        rst_b_in,
   input wire logic [7:0]  reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic        reg_wr_in,
   input wire logic        external_frame_trigger_in,
   input wire logic [3:0]  tap_count_out,
   input wire logic        pix_depth10_out,
   input wire logic        exposing_out,
   input wire logic        ctl_sig_out,
   input wire logic        readout_start_out
);
   logic [2:0]  om;
   logic [2:0]  xm;
   logic [31:0] raw, frm, expc, rdc, lowc;
   logic        seen, ex_ok;
   wire  [2:0]  cd = reg_wdata_in[2:0];
   wire         cd_ok = cd <= 3'h4;
   wire  [31:0] rv = (reg_wdata_in[21:0] == 22'h0) ? 32'h1 :
                     {10'h0, reg_wdata_in[21:0]};
   wire  [31:0] qv = reg_wdata_in / `EFT_ABS_PER_STEP;
   wire  [31:0] av = (qv == 32'h0) ? 32'h1 : qv;
   wire  [3:0]  tc_exp = (om < 3'h2) ? 4'h2 : (om < 3'h4) ? 4'h4 : 4'h8;
   wire  [31:0] step = `EFT_LINE_STEP_CYC;

   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   // register shadows, interval counters and validity flags
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         om <= 3'h0;
         xm <= 3'h0;
         raw <= 32'h1;
         frm <= 32'h100;
         seen <= 1'b0;
         ex_ok <= 1'b0;
         expc <= 32'h0;
         rdc <= 32'h0;
         lowc <= 32'h0;
      end else begin
         seen <= !reg_wr_in && (seen || readout_start_out);
         ex_ok <= !reg_wr_in &&
                  (ex_ok || (xm == 3'h2 && $rose(exposing_out)));
         expc <= exposing_out ? expc + 32'h1 : 32'h0;
         lowc <= ctl_sig_out ? 32'h0 : lowc + 32'h1;
         rdc <= readout_start_out ? 32'h1 : rdc + 32'h1;
         if (reg_wr_in) begin
            case (reg_addr_in)
               8'h00: if (cd_ok) om <= cd;
               8'h04: if (cd_ok) xm <= cd;
               8'h08: raw <= rv;
               8'h0C: raw <= av;
               8'h10: frm <= rv;
               8'h14: frm <= av;
               default: ;
            endcase
         end
      end
   end

   sequence s_rise;
      $rose(external_frame_trigger_in);
   endsequence
   sequence s_fall;
      $fell(external_frame_trigger_in);
   endsequence
   sequence s_prg_end;
      xm == 3'h2 && ex_ok && $fell(exposing_out);
   endsequence

   AST_OM_CNT:
   assert property (tap_count_out == tc_exp)
      else $error("tap count does not follow output mode");
   AST_DEPTH:
   assert property (pix_depth10_out == (om == 3'h0 || om == 3'h2))
      else $error("pixel depth does not follow output mode");
   AST_TRIG_RISE:
   assert property (s_rise ##0 xm <= 3'h1 |-> ##[1:6] readout_start_out)
      else $error("no readout after trigger rise");
   AST_FALL_IGN:
   assert property (s_fall ##0 xm == 3'h0 |-> !readout_start_out [*6])
      else $error("readout after falling trigger in edge mode");
   AST_LVL_EXP:
   assert property (s_fall ##0 xm == 3'h1 |-> ##[1:6] exposing_out)
      else $error("no exposure while trigger low");
   AST_PRG_START:
   assert property (s_rise ##0 (xm == 3'h2 && !exposing_out)
                    |-> ##[1:6] $rose(exposing_out))
      else $error("programmed exposure did not start");
   AST_PRG_LEN:
   assert property (s_prg_end |-> expc == raw * step)
      else $error("programmed exposure length wrong");
   AST_PRG_END:
   assert property (s_prg_end |-> readout_start_out)
      else $error("readout not at end of exposure");
   AST_FREE_PER:
   assert property (readout_start_out && seen && xm >= 3'h3
                    |-> rdc == frm * step)
      else $error("free-run period wrong");
   AST_FREE_LOW:
   assert property ($rose(ctl_sig_out) && seen && xm == 3'h4
                    |-> lowc == raw * step)
      else $error("free-run low time wrong");
endmodule  // eft_top_props

bind eft_top eft_top_props chk_u (
   .sys_clk_in                (sys_clk_in),
   .rst_b_in                  (rst_b_in),
   .reg_addr_in               (reg_addr_in),
   .reg_wdata_in              (reg_wdata_in),
   .reg_wr_in                 (reg_wr_in),
   .external_frame_trigger_in (external_frame_trigger_in),
   .tap_count_out             (tap_count_out),
   .pix_depth10_out           (pix_depth10_out),
   .exposing_out              (exposing_out),
   .ctl_sig_out               (ctl_sig_out),
   .readout_start_out         (readout_start_out)
);

// File: dv/eft_grabber_model.sv
// Purpose: frame grabber model driving trigger and pixel clock
// Assumes: trigger widths counted in 20 ns system clocks
// Notes  : pixel clock stands low while pclk_en_in is low
module eft_grabber_model (
   input  wire logic sys_clk_in,
   input  wire logic pclk_en_in,
   output logic      trig_out,
   output logic      pclk_out
);
   timeunit 1ns;
   timeprecision 1ps;

   // 160 ns pixel clock, phase offset from the system clock
   initial begin
      trig_out = 1'b0;
      pclk_out = 1'b0;
      #7;
      forever #80 pclk_out = pclk_en_in ? ~pclk_out : 1'b0;
   end

   // one trigger pulse, widths raised to the legal minimums
   task automatic pulse(input int hi, input int lo, input logic lev);
      int h;
      int l;
      h = (lev && hi < 456) ? 456 : (hi < 100) ? 100 : hi;
      l = (lev && lo < 228) ? 228 : (lo < 100) ? 100 : lo;
      @(posedge sys_clk_in);
      trig_out <= 1'b1;
      repeat (h) @(posedge sys_clk_in);
      trig_out <= 1'b0;
      repeat (l - 1) @(posedge sys_clk_in);  // next call's edge ends low
   endtask
endmodule  // eft_grabber_model

// File: dv/eft_top_tb.sv
// Purpose: self-checking bench for the exposure and frame timing control
// Assumes: 50 MHz clock; grabber model makes trigger and pixel clock
// Notes  : models sample on the falling edge, away from the drive edge
module eft_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
   logic        sv = 1'b0, pen = 1'b0, pend = 1'b0, expv;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0, rdv, c0, rdata, xs = 32'h00004648;
   logic [79:0] sd = 80'h0, tap, expd;
   logic [9:0]  px;
   logic [3:0]  tcnt;
   logic [2:0]  om = 3'h0;
   logic        tval, d10, expo, ctl, ros, trig, pclk, sry;
   int num_errors = 0, n_checks = 0, cyc = 0, lastp = 0, gap = 0, np = 0;
   int hi = 0, lastexp = 0, lo = 0, lastlo = 0, n0;

   eft_top dut_u (
      .sys_clk_in(clk), .rst_b_in(rst_b), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .external_frame_trigger_in(trig),
      .pix_clk_in(pclk), .src_data_in(sd), .src_valid_in(sv),
      .src_ready_out(sry), .tap_data_out(tap), .tap_valid_out(tval),
      .tap_count_out(tcnt), .pix_depth10_out(d10), .exposing_out(expo),
      .ctl_sig_out(ctl), .readout_start_out(ros));
   eft_grabber_model fg_u (.sys_clk_in(clk), .pclk_en_in(pen),
      .trig_out(trig), .pclk_out(pclk));

   always #10 clk = ~clk;

   function automatic logic [31:0] xsh(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   function automatic int tcm(input logic [2:0] m);
      return (m < 3'h2) ? 2 : (m < 3'h4) ? 4 : 8;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wrr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      rdv = rdata;
      chk(rdv, e);
   endtask
   task automatic test_done;
      $display("errors %0d checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // random pixel words and valid flag
   always @(posedge clk) begin
      xs <= xsh(xs);
      sd <= {xs[15:0], xs, ~xs};
      sv <= xs[3];
   end
   // tap model: capture at a ready pulse, compare a cycle later
   always @(negedge clk) begin
      if (pend) begin
         n_checks++;
         if (tap !== expd || tval !== expv) begin
            num_errors++;
            $display("[FAIL] %0t tap word mismatch", $time);
         end
      end
      pend = sry && rst_b;
      expv = sv;
      for (int i = 0; i < 8; i++) begin
         px = sd[i*10 +: 10];
         if (i >= tcm(om) || !sv) expd[i*10 +: 10] = 10'h000;
         else if (om == 3'h0 || om == 3'h2) expd[i*10 +: 10] = px;
         else expd[i*10 +: 10] = {2'h0, px[9:2]};
      end
   end
   // pulse spacing, exposure length and control low time
   always @(negedge clk) begin
      cyc++;
      if (ros) begin
         gap = cyc - lastp;
         lastp = cyc;
         np++;
      end
      if (expo) hi++;
      else if (hi != 0) begin
         lastexp = hi;
         hi = 0;
      end
      if (!ctl) lo++;
      else if (lo != 0) begin
         lastlo = lo;
         lo = 0;
      end
   end
   // watchdog
   initial begin
      #1800000;
      num_errors++;
      test_done;
   end

   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      pen <= 1'b1;
      // reset values, unmapped address, refused values
      rchk(8'h00, 32'h0);
      rchk(8'h04, 32'h0);
      rchk(8'h08, 32'h1);
      rchk(8'h10, 32'h100);
      rchk(8'h20, 32'h0);
      wrr(8'h08, 32'h0);
      rchk(8'h08, 32'h1);
      wrr(8'h04, 32'h7);
      rchk(8'h04, 32'h0);
      // every output mode, then a refused code
      for (int m = 0; m < 6; m++) begin
         wrr(8'h00, 32'(m));
         if (m < 5) om = 3'(m);
         repeat (40) @(posedge clk);
         chk(32'(tcnt), 32'(tcm(om)));
         chk(32'(d10), 32'(om == 3'h0 || om == 3'h2));
      end
      // trigger edge mode: one frame per rising edge
      wrr(8'h04, 32'h0);
      rchk(8'h1C, 32'h0);
      c0 = rdv;
      rchk(8'h1C, c0);
      n0 = np;
      repeat (3) fg_u.pulse(150, 150, 1'b0);
      chk(32'(np - n0), 32'h3);
      rchk(8'h1C, c0 + 32'h3);
      // level mode: exposure spans the low time
      wrr(8'h04, 32'h1);
      fg_u.pulse(500, 300, 1'b1);
      chk(32'(expo), 32'h1);
      n0 = np;
      fg_u.pulse(500, 300, 1'b1);
      chk(32'(np - n0), 32'h1);
      chk(32'(lastexp), 32'(300));
      rchk(8'h18, 32'h1);
      // programmable mode, raw and absolute exposure
      wrr(8'h08, 32'h2);
      wrr(8'h04, 32'h2);
      fg_u.pulse(150, 700, 1'b0);
      chk(32'(lastexp), 32'(2 * 228));
      wrr(8'h0C, 32'(1000));
      repeat (40) @(posedge clk);
      rchk(8'h08, 32'(1000 / 456));
      rchk(8'h0C, 32'(1000 / 456 * 456));
      wrr(8'h0C, 32'(100));
      repeat (40) @(posedge clk);
      rchk(8'h08, 32'h1);
      fg_u.pulse(150, 400, 1'b0);
      chk(32'(lastexp), 32'(228));
      // free-run edge mode, period set as absolute time
      wrr(8'h14, 32'(2 * 456));
      repeat (40) @(posedge clk);
      rchk(8'h10, 32'h2);
      rchk(8'h14, 32'(2 * 456));
      wrr(8'h04, 32'h3);
      n0 = np;
      repeat (2000) @(posedge clk);
      chk(32'(gap), 32'(2 * 228));
      chk(32'(np - n0 >= 4), 32'h1);
      // free-run programmable mode, exposure kept below the period
      wrr(8'h04, 32'h0);
      wrr(8'h08, 32'h2);
      wrr(8'h10, 32'h5);
      wrr(8'h04, 32'h4);
      repeat (3000) @(posedge clk);
      chk(32'(gap), 32'(5 * 228));
      chk(32'(lastlo), 32'(2 * 228));
      test_done;
   end
endmodule  // eft_top_tb
